// ---- hdl/cfg_port_pkg.sv ----
// Constants shared by the configuration serial port design
package cfg_port_pkg;
    // Transaction layout: read flag, 7-bit address, 8-bit data
    localparam int unsigned ADDR_BITS = 7;
    localparam int unsigned DATA_BITS = 8;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] HEAD_BITS = 5'h08;
    // Configuration register addresses
    localparam logic [6:0] ADDR_PORT_CFG = 7'h01;
    localparam logic [6:0] ADDR_DEV_CTRL = 7'h02;
    // Field positions
    localparam int unsigned FIELD_FOUR_WIRE = 0;
    localparam int unsigned FIELD_CHAN0_READ = 1;
    localparam int unsigned FIELD_REF_BUF_EN = 0;
    localparam int unsigned FIELD_BANDGAP_EN = 1;
    // Values after reset
    localparam logic [7:0] PORT_CFG_RESET = 8'h00;
    localparam logic [7:0] DEV_CTRL_RESET = 8'h03;
    // Scratch register reset value, arbitrary
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [6:0] ADDR_SCRATCH = 7'h03;
endpackage

// ---- hdl/cfg_serial_port.sv ----
// Configuration serial port with bus format strap and reference controls
`timescale 1ns/1ns
`default_nettype none
module cfg_serial_port (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial port pins
    input wire logic cs_n,
    input wire logic cfg_serial_clock,
    input wire logic cfg_serial_io_in,
    output logic cfg_serial_io_out,
    output logic cfg_serial_io_oe,
    output logic cfg_serial_out,
    output logic cfg_serial_out_oe,
    // Bus format strap and conversion bus control
    input wire logic bus_format_strap,
    output logic lvds_mode,
    output logic conv_bus_enable,
    // Channel zero data output override
    input wire logic channel_zero_conv_data,
    output logic channel_zero_data_out,
    output logic channel_zero_data_oe,
    // Reference controls
    output logic ref_buffer_enable,
    output logic bandgap_enable,
    // Configuration state
    output logic four_wire_mode
);
    logic rst_s1;
    logic rst_n_sync;
    logic cs_n_s;
    logic sck_s;
    logic sdi_s;
    logic strap_s;

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1 <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n_sync <= rst_s1;
        end
    end

    // Pin synchronisers; chip select rests deselected so reset is no frame
    sync2 #(.RESET_LEVEL(1'b1)) u_sync_cs (.clk(clk), .rst_n(rst_n_sync),
        .async_in(cs_n), .sync_out(cs_n_s));
    sync2 u_sync_sck (.clk(clk), .rst_n(rst_n_sync),
        .async_in(cfg_serial_clock), .sync_out(sck_s));
    sync2 u_sync_sdi (.clk(clk), .rst_n(rst_n_sync),
        .async_in(cfg_serial_io_in), .sync_out(sdi_s));
    sync2 u_sync_strap (.clk(clk), .rst_n(rst_n_sync),
        .async_in(bus_format_strap), .sync_out(strap_s));

    // Serial state
    logic sck_q;
    logic cs_q;
    logic idle_level;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic rd_phase;
    logic sdo_bit;
    logic [7:0] port_cfg;
    logic [7:0] dev_ctrl;
    logic [7:0] scratch;
    logic next_sck_q;
    logic next_cs_q;
    logic next_idle_level;
    logic [4:0] next_bit_cnt;
    logic [15:0] next_shift_in;
    logic [7:0] next_shift_out;
    logic next_rd_phase;
    logic next_sdo_bit;
    logic [7:0] next_port_cfg;
    logic [7:0] next_dev_ctrl;
    logic [7:0] next_scratch;
    logic sample_edge;
    logic launch_edge;
    logic sck_edge;
    logic frame_start;
    logic [15:0] shifted;

    // Register read mux
    function automatic logic [7:0] read_reg(input logic [6:0] addr,
        input logic [7:0] pc, input logic [7:0] dc, input logic [7:0] sc);
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            cfg_port_pkg::ADDR_PORT_CFG: val = pc;
            cfg_port_pkg::ADDR_DEV_CTRL: val = dc;
            cfg_port_pkg::ADDR_SCRATCH: val = sc;
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // Edge detection; idle level captured at frame start
    always_comb begin
        frame_start = cs_q && !cs_n_s;
        sck_edge = (sck_s != sck_q) && !cs_n_s && !frame_start;
        // Mode 0 when idle low, mode 2 when idle high
        sample_edge = sck_edge && (sck_s == !idle_level);
        launch_edge = sck_edge && (sck_s == idle_level);
    end

    // Next-state of the serial engine
    always_comb begin
        next_sck_q = sck_s;
        next_cs_q = cs_n_s;
        next_idle_level = idle_level;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        next_rd_phase = rd_phase;
        next_sdo_bit = sdo_bit;
        next_port_cfg = port_cfg;
        next_dev_ctrl = dev_ctrl;
        next_scratch = scratch;
        shifted = {shift_in[14:0], sdi_s};
        if (cs_n_s) begin
            next_bit_cnt = 5'h00;
            next_rd_phase = 1'b0;
            next_sdo_bit = 1'b0;
        end else if (frame_start) begin
            next_idle_level = sck_s;
            next_bit_cnt = 5'h00;
        end else if (sample_edge && bit_cnt < cfg_port_pkg::FRAME_BITS) begin
            // Input is always taken from the IO pin
            next_shift_in = shifted;
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt + 5'h01 == cfg_port_pkg::HEAD_BITS && shifted[7]) begin
                next_rd_phase = 1'b1;
                next_shift_out = read_reg(shifted[6:0], port_cfg,
                    dev_ctrl, scratch);
            end
            if (bit_cnt + 5'h01 == cfg_port_pkg::FRAME_BITS
                && !shifted[15]) begin
                unique case (shifted[14:8])
                    cfg_port_pkg::ADDR_PORT_CFG: next_port_cfg = shifted[7:0];
                    cfg_port_pkg::ADDR_DEV_CTRL: next_dev_ctrl = shifted[7:0];
                    cfg_port_pkg::ADDR_SCRATCH: next_scratch = shifted[7:0];
                    default: next_scratch = scratch;
                endcase
            end
        end else if (launch_edge && rd_phase) begin
            next_sdo_bit = shift_out[7];
            next_shift_out = {shift_out[6:0], 1'b0};
            if (bit_cnt == cfg_port_pkg::FRAME_BITS) begin
                next_rd_phase = 1'b0;
            end
        end
    end

    // Register serial engine state
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            idle_level <= 1'b0;
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
            shift_out <= 8'h00;
            rd_phase <= 1'b0;
            sdo_bit <= 1'b0;
            port_cfg <= cfg_port_pkg::PORT_CFG_RESET;
            dev_ctrl <= cfg_port_pkg::DEV_CTRL_RESET;
            scratch <= cfg_port_pkg::SCRATCH_RESET;
        end else begin
            sck_q <= next_sck_q;
            cs_q <= next_cs_q;
            idle_level <= next_idle_level;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
            rd_phase <= next_rd_phase;
            sdo_bit <= next_sdo_bit;
            port_cfg <= next_port_cfg;
            dev_ctrl <= next_dev_ctrl;
            scratch <= next_scratch;
        end
    end

    // Pin drivers; wire mode independent of strap
    always_comb begin
        four_wire_mode = port_cfg[cfg_port_pkg::FIELD_FOUR_WIRE];
        cfg_serial_io_out = sdo_bit;
        cfg_serial_out = sdo_bit;
        // IO pin drives read data only in three-wire mode
        cfg_serial_io_oe = !cs_n_s && rd_phase && !four_wire_mode;
        // Dedicated output released in three-wire mode
        cfg_serial_out_oe = !cs_n_s && rd_phase && four_wire_mode;
        lvds_mode = strap_s;
        conv_bus_enable = !cs_n_s;
        // Channel zero carries read data in four-wire mode when enabled
        if (four_wire_mode && rd_phase
            && port_cfg[cfg_port_pkg::FIELD_CHAN0_READ]) begin
            channel_zero_data_out = sdo_bit;
        end else begin
            channel_zero_data_out = channel_zero_conv_data;
        end
        channel_zero_data_oe = !cs_n_s && !strap_s;
        ref_buffer_enable = dev_ctrl[cfg_port_pkg::FIELD_REF_BUF_EN];
        bandgap_enable = dev_ctrl[cfg_port_pkg::FIELD_BANDGAP_EN];
    end
endmodule
`default_nettype wire

// ---- hdl/sync2.sv ----
// Two flip-flop synchroniser for a single level
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    // Level held while in reset, the idle level of the pin
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and synchronised level out
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    // Next values are the previous stage
    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    // Register both stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RESET_LEVEL;
            sync_out <= RESET_LEVEL;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule
`default_nettype wire

// ---- sim/cfg_host.sv ----
// Host model driving the configuration serial port
`timescale 1ns/1ns
`default_nettype none
module cfg_host (
    // Device pins seen by the host
    input wire logic io_oe,
    input wire logic io_out,
    input wire logic s_out,
    input wire logic c0_out,
    // Pins driven by the host
    output logic cs_n = 1'b1,
    output logic sck = 1'b0,
    output logic io_wire
);
    logic h_oe = 1'b0;
    logic h_bit = 1'b0;
    logic [7:0] z0;
    // Released line drifts to the inverse of the last host bit
    always_comb io_wire = io_oe ? io_out : h_oe ? h_bit : !h_bit;
    // One frame, MSB first, clock resting at idle; pins move by NBA
    task automatic xfer(input logic [15:0] f, input logic idle,
                        input logic fw, output logic [7:0] rd);
        sck <= idle;
        #200 cs_n <= 1'b0;
        #320;
        for (int i = 15; i >= 0; i--) begin
            h_oe <= fw || !(f[15] && i < 8);
            h_bit <= f[i];
            #160 sck <= ~idle;
            #80 if (i < 8) begin
                rd[i] = fw ? s_out : io_wire;
                z0[i] = c0_out;
            end
            #80 sck <= idle;
        end
        #160 cs_n <= 1'b1;
        h_oe <= 1'b0;
        #400;
    endtask
endmodule
`default_nettype wire

// ---- sim/cfg_serial_port_properties.sv ----
// Checker for the configuration serial port pins
`timescale 1ns/1ns
`default_nettype none
module cfg_serial_port_check (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Watched pins
    input wire logic cs_n,
    input wire logic bus_format_strap,
    input wire logic cfg_serial_io_oe,
    input wire logic cfg_serial_out_oe,
    input wire logic lvds_mode,
    input wire logic conv_bus_enable,
    input wire logic channel_zero_data_oe,
    input wire logic ref_buffer_enable,
    input wire logic bandgap_enable,
    input wire logic four_wire_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Pin release, bus enable and output ownership
    a_idle_release: assert property (cs_n [*5] |->
        !cfg_serial_io_oe && !cfg_serial_out_oe) else $error("oe while idle");
    a_bus_off_idle: assert property (cs_n [*5] |-> !conv_bus_enable)
        else $error("bus enabled while idle");
    a_bus_on_select: assert property ((!cs_n) [*4] |-> conv_bus_enable)
        else $error("bus disabled while selected");
    a_three_quiet: assert property (!four_wire_mode |->
        !cfg_serial_out_oe) else $error("out driven in three-wire");
    a_four_io_free: assert property (four_wire_mode |->
        !cfg_serial_io_oe) else $error("io driven in four-wire");
    a_strap_lvds: assert property (bus_format_strap [*7] |->
        lvds_mode) else $error("strap high not seen");
    a_strap_cmos: assert property ((!cs_n && !bus_format_strap) [*7] |->
        !lvds_mode && channel_zero_data_oe) else $error("cmos output");
    a_lvds_chan0: assert property (lvds_mode |->
        !channel_zero_data_oe) else $error("chan0 driven in lvds");
    a_cfg_hold: assert property (cs_n [*4] |-> $stable(four_wire_mode) &&
        $stable(ref_buffer_enable) && $stable(bandgap_enable))
        else $error("config moved while idle");
endmodule
bind cfg_serial_port cfg_serial_port_check u_check (.clk(clk),
    .reset_n(reset_n), .cs_n(cs_n), .bus_format_strap(bus_format_strap),
    .cfg_serial_io_oe(cfg_serial_io_oe),
    .cfg_serial_out_oe(cfg_serial_out_oe), .lvds_mode(lvds_mode),
    .conv_bus_enable(conv_bus_enable),
    .channel_zero_data_oe(channel_zero_data_oe),
    .ref_buffer_enable(ref_buffer_enable), .bandgap_enable(bandgap_enable),
    .four_wire_mode(four_wire_mode));
`default_nettype wire

// ---- sim/config_spi_port_and_bus_select_bench.sv ----
// Bench for the configuration serial port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module config_spi_port_and_bus_select_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic strap = 1'b0;
    logic c0 = 1'b1;
    int checked = 0;
    int n_fail = 0;
    int cyc = 0;
    wire logic cs_n, sck, io, io_out, io_oe, s_out, s_oe, lvds, conv_en;
    wire logic c0_out, c0_oe, rbe, bge, fw;
    always #20 clk = ~clk;
    cfg_serial_port dut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
        .cfg_serial_clock(sck), .cfg_serial_io_in(io),
        .cfg_serial_io_out(io_out), .cfg_serial_io_oe(io_oe),
        .cfg_serial_out(s_out), .cfg_serial_out_oe(s_oe),
        .bus_format_strap(strap), .lvds_mode(lvds), .conv_bus_enable(conv_en),
        .channel_zero_conv_data(c0), .channel_zero_data_out(c0_out),
        .channel_zero_data_oe(c0_oe), .ref_buffer_enable(rbe),
        .bandgap_enable(bge), .four_wire_mode(fw));
    cfg_host host (.io_oe(io_oe), .io_out(io_out), .s_out(s_out),
        .c0_out(c0_out), .cs_n(cs_n), .sck(sck), .io_wire(io));
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // Strap selects the output format
    task automatic t_strap;
        strap <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(lvds, 1'b1)
        strap <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(lvds, 1'b0)
        `CHK(conv_en, 1'b0)
    endtask
    // Three-wire write then reads, both idle levels and strap settings
    task automatic t_three_wire;
        logic [7:0] d;
        host.xfer({1'b0, cfg_port_pkg::ADDR_SCRATCH, 8'ha5}, 1'b0, 1'b0, d);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            strap <= k[0];
            host.xfer({1'b1, cfg_port_pkg::ADDR_SCRATCH, 8'h00}, k[0], 1'b0, d);
            `CHK(d, 8'ha5)
        end
        @(posedge clk);
        strap <= 1'b0;
    endtask
    // Four-wire reads, channel zero copy, reference controls
    task automatic t_four_wire;
        logic [7:0] d;
        host.xfer({1'b0, cfg_port_pkg::ADDR_PORT_CFG, 8'h03}, 1'b1, 1'b0, d);
        `CHK(fw, 1'b1)
        host.xfer({1'b1, cfg_port_pkg::ADDR_SCRATCH, 8'h00}, 1'b0, 1'b1, d);
        `CHK(d, 8'ha5)
        `CHK(host.z0, 8'ha5)
        host.xfer({1'b1, 7'h7f, 8'h00}, 1'b0, 1'b1, d);
        `CHK(d, 8'h00)
        `CHK({io_oe, s_oe, c0_oe, conv_en}, 4'h0)
        host.xfer({1'b0, cfg_port_pkg::ADDR_PORT_CFG, 8'h01}, 1'b0, 1'b1, d);
        host.xfer({1'b1, cfg_port_pkg::ADDR_SCRATCH, 8'h00}, 1'b0, 1'b1, d);
        `CHK(d, 8'ha5)
        `CHK(host.z0, 8'hff)
        host.xfer({1'b0, cfg_port_pkg::ADDR_DEV_CTRL, 8'h00}, 1'b1, 1'b1, d);
        `CHK({rbe, bge}, 2'b00)
        host.xfer({1'b0, cfg_port_pkg::ADDR_PORT_CFG, 8'h00}, 1'b0, 1'b1, d);
        `CHK(fw, 1'b0)
    endtask
    // Reset, then each scenario in turn
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK({rbe, bge, fw, io_oe, s_oe}, 5'h18)
        t_strap();
        t_three_wire();
        t_four_wire();
        tally_and_finish();
    end
endmodule
`default_nettype wire
